// ==== rtl/otp_seq_pkg.sv ====
// constants and types shared by the otp access sequencer
package otp_seq_pkg;
    // byte offsets inside the otp interface register file
    localparam logic [6:0]  OFF_WDAT      = 7'h00;
    localparam logic [6:0]  OFF_ADR       = 7'h04;
    localparam logic [6:0]  OFF_CTRL      = 7'h06;
    localparam logic [6:0]  OFF_CTRL_HI   = 7'h07;
    localparam logic [6:0]  OFF_RDAT      = 7'h0A;
    localparam logic [6:0]  OFF_SPECIAL   = 7'h12;
    localparam logic [6:0]  WORD_BYTES    = 7'h04;
    localparam logic [6:0]  HALF_BYTES    = 7'h02;

    // link header layout
    localparam int          HDR_WR_POS    = 7;

    // otp array geometry
    localparam int          OTP_AW        = 11;
    localparam int          OTP_WORDS     = 2048;
    localparam logic [10:0] SPECIAL_ADDR  = 11'h400;

    // control byte encodings
    localparam logic [1:0]  CTRL_READ_VAL = 2'h3;
    localparam int          CTRL_PROG_POS = 6;
    localparam logic [7:0]  CTRL_CFG_LOAD = 8'h08;
    localparam logic [7:0]  STAGE1_HI     = 8'h03;
    localparam logic [7:0]  STAGE2_HI     = 8'h05;
    localparam logic [7:0]  STAGE3_HI     = 8'h01;
    localparam logic [1:0]  LAST_STAGE    = 2'h2;

    // special word fields
    localparam int          SPW_EN_HI     = 4;
    localparam int          SPW_EN_LO     = 3;
    localparam logic [1:0]  SPW_EN_VAL    = 2'h1;
    localparam int          SPW_PH_POS    = 1;
    localparam int          SPW_POL_POS   = 0;

    // reset values and timing
    localparam logic [31:0] WDAT_RST      = 32'h0000_0000;
    localparam logic [15:0] ADR_RST       = 16'h0000;
    localparam logic [15:0] CTRL_RST      = 16'h0000;
    localparam logic [31:0] RDAT_RST      = 32'h0000_0000;
    localparam logic [31:0] SPECIAL_RST   = 32'h0000_0000;
    localparam logic [1:0]  STRAP_SETTLE  = 2'h3;

    typedef enum logic [1:0] {ST_BOOT, ST_BOOT_WAIT, ST_IDLE, ST_READ_WAIT} seq_state_e;
endpackage

// ==== rtl/otp_word_array.sv ====
// one-time-programmable word array with registered read port
`timescale 1ns/10ps
module otp_word_array
    import otp_seq_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              resetn_in,
    input  wire logic              rd_en_in,
    input  wire logic              wr_en_in,
    input  wire logic [OTP_AW-1:0] addr_in,
    input  wire logic [31:0]       wdata_in,
    output logic      [31:0]       rdata_out
);
    logic [31:0] cells [OTP_WORDS];

    // blank fuses read as zero
    initial begin
        for (int i = 0; i < OTP_WORDS; i++) begin
            cells[i] = 32'h0000_0000;
        end
    end

    // fuses only ever set, so programming ors into the cell
    always @(posedge clk_in) begin
        if (wr_en_in) begin
            cells[addr_in] <= cells[addr_in] | wdata_in;
        end
    end

    // read data held until the next read
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata_out <= 32'h0000_0000;
        end else if (rd_en_in) begin
            rdata_out <= cells[addr_in];
        end
    end
endmodule

// ==== rtl/otp_program_read_sequencer.sv ====
// otp access sequencer: serial register link, otp control and special boot word
`timescale 1ns/10ps
module otp_program_read_sequencer
    import otp_seq_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic resetn_in,
    input  wire logic link_clk_in,
    input  wire logic link_sel_n_in,
    input  wire logic link_mosi_in,
    output logic      link_miso_out,
    output logic      link_miso_oe_out,
    input  wire logic mode_strap_pin_high_in,
    input  wire logic mode_strap_pin_low_in,
    output logic      serial_clock_phase_out,
    output logic      serial_clock_polarity_out,
    output logic      prog_config_active_out
);
    // ---- link domain: frame state
    logic [2:0] bit_cnt_q;
    logic [6:0] rx_sh_q;
    logic       hdr_done_q;
    logic       is_wr_q;
    logic [6:0] addr_q;
    logic [7:0] tx_q;
    logic       miso_q;

    // ---- link domain: request and ack crossing
    logic       req_tgl_q;
    logic       req_wr_q;
    logic [6:0] req_addr_q;
    logic [7:0] req_data_q;
    logic       ack_s1_q;
    logic       ack_s2_q;
    logic       ack_s3_q;

    // ---- system domain
    logic       req_s1_q;
    logic       req_s2_q;
    logic       req_s3_q;
    logic       req_seen_q;
    logic       ack_tgl_q;
    logic [7:0] rd_byte_q;
    logic [31:0] wdat_q;
    logic [15:0] adr_q;
    logic [15:0] ctrl_q;
    logic [31:0] rdat_q;
    logic [31:0] special_q;
    logic [1:0] cfg_stage_q;
    logic       armed_q;
    logic [1:0] strap_s1_q;
    logic [1:0] strap_s2_q;
    logic [1:0] strap_s3_q;
    logic [1:0] strap_q;
    logic [1:0] strap_age_q;
    logic       strap_taken_q;
    logic       phase_q;
    logic       pol_q;
    logic [31:0] mem_rdata;
    seq_state_e state_q;
    seq_state_e state_d;

    function automatic logic [7:0] pick(input logic [31:0] w, input logic [1:0] b);
        pick = w[{b, 3'h0} +: 8];
    endfunction

    // link byte assembly; mode 0 framing, header bit 7 selects write
    wire [7:0] rx_byte    = {rx_sh_q, link_mosi_in};
    wire       byte_end   = (bit_cnt_q == 3'h7);
    wire       issue      = byte_end && (hdr_done_q || !rx_byte[HDR_WR_POS]);
    wire [6:0] next_addr  = addr_q + 7'h01;
    wire [6:0] hdr_addr   = rx_byte[6:0];
    wire [6:0] data_addr  = is_wr_q ? addr_q : next_addr;
    wire [6:0] issue_addr = hdr_done_q ? data_addr : hdr_addr;
    wire       ack_ok     = (ack_s2_q == ack_s3_q) && (ack_s3_q == req_tgl_q);

    // frame state ends with the frame: deselect clears it asynchronously
    always_ff @(posedge link_clk_in or posedge link_sel_n_in) begin
        if (link_sel_n_in) begin
            bit_cnt_q  <= 3'h0;
            rx_sh_q    <= 7'h00;
            hdr_done_q <= 1'b0;
            is_wr_q    <= 1'b0;
            addr_q     <= 7'h00;
            tx_q       <= 8'h00;
        end else begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            rx_sh_q   <= rx_byte[6:0];
            tx_q      <= {tx_q[6:0], 1'b0};
            if (byte_end) begin
                hdr_done_q <= 1'b1;
                if (!hdr_done_q) begin
                    is_wr_q <= rx_byte[HDR_WR_POS];
                    addr_q  <= hdr_addr;
                end else begin
                    addr_q <= next_addr;
                end
                // reads lag one byte so the fetch has a whole byte to cross
                if (hdr_done_q && !is_wr_q) begin
                    tx_q <= ack_ok ? rd_byte_q : 8'h00;
                end
            end
        end
    end

    // miso changes on the falling edge, host samples on the rising one
    always_ff @(negedge link_clk_in or posedge link_sel_n_in) begin
        if (link_sel_n_in) begin
            miso_q <= 1'b0;
        end else begin
            miso_q <= tx_q[7];
        end
    end

    assign link_miso_out    = miso_q;
    assign link_miso_oe_out = !link_sel_n_in && hdr_done_q && !is_wr_q;

    // request word held stable while its toggle crosses
    always_ff @(posedge link_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            req_tgl_q  <= 1'b0;
            req_wr_q   <= 1'b0;
            req_addr_q <= 7'h00;
            req_data_q <= 8'h00;
        end else if (!link_sel_n_in && issue) begin
            req_tgl_q  <= ~req_tgl_q;
            req_wr_q   <= hdr_done_q && is_wr_q;
            req_addr_q <= issue_addr;
            req_data_q <= rx_byte;
        end
    end

    // ack toggle back into the link domain
    always_ff @(posedge link_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            ack_s3_q <= 1'b0;
        end else begin
            ack_s1_q <= ack_tgl_q;
            ack_s2_q <= ack_s1_q;
            ack_s3_q <= ack_s2_q;
        end
    end

    // request toggle into the system domain
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            req_s3_q <= 1'b0;
        end else begin
            req_s1_q <= req_tgl_q;
            req_s2_q <= req_s1_q;
            req_s3_q <= req_s2_q;
        end
    end

    // access decode, valid once the second and third stages agree
    wire       req_ev     = (req_s2_q == req_s3_q) && (req_s3_q != req_seen_q);
    wire       ev_wr      = req_ev && req_wr_q;
    wire       ev_rd      = req_ev && !req_wr_q;
    wire [6:0] i_wdat     = req_addr_q - OFF_WDAT;
    wire [6:0] i_adr      = req_addr_q - OFF_ADR;
    wire [6:0] i_ctrl     = req_addr_q - OFF_CTRL;
    wire [6:0] i_rdat     = req_addr_q - OFF_RDAT;
    wire [6:0] i_spw      = req_addr_q - OFF_SPECIAL;
    wire       hit_wdat   = i_wdat < WORD_BYTES;
    wire       hit_adr    = i_adr < HALF_BYTES;
    wire       hit_ctrl   = i_ctrl < HALF_BYTES;
    wire       hit_rdat   = i_rdat < WORD_BYTES;
    wire       hit_spw    = i_spw < WORD_BYTES;

    // read mux; unmapped bytes read as zero
    wire [7:0] rd_wdat    = pick(wdat_q, i_wdat[1:0]);
    wire [7:0] rd_adr     = pick({16'h0000, adr_q}, {1'b0, i_adr[0]});
    wire [7:0] rd_ctrl    = pick({16'h0000, ctrl_q}, {1'b0, i_ctrl[0]});
    wire [7:0] rd_rdat    = pick(rdat_q, i_rdat[1:0]);
    wire [7:0] rd_spw     = pick(special_q, i_spw[1:0]);
    wire [7:0] rd_mux     = hit_wdat ? rd_wdat :
                            hit_adr  ? rd_adr  :
                            hit_ctrl ? rd_ctrl :
                            hit_rdat ? rd_rdat :
                            hit_spw  ? rd_spw  : 8'h00;

    // answer every request; read bytes are held for the link to sample
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            req_seen_q <= 1'b0;
            ack_tgl_q  <= 1'b0;
            rd_byte_q  <= 8'h00;
        end else if (req_ev) begin
            req_seen_q <= req_s3_q;
            ack_tgl_q  <= req_s3_q;
            if (ev_rd) begin
                rd_byte_q <= rd_mux;
            end
        end
    end

    // control byte effects
    wire       ctrl_lo_wr = ev_wr && (req_addr_q == OFF_CTRL);
    wire       rd_pulse   = ctrl_lo_wr && (req_data_q[1:0] == CTRL_READ_VAL);
    wire       prog_pulse = ctrl_lo_wr && req_data_q[CTRL_PROG_POS];
    wire       load_pulse = ctrl_lo_wr && (req_data_q == CTRL_CFG_LOAD);
    wire [7:0] stage_hi   = (cfg_stage_q == 2'h0) ? STAGE1_HI :
                            (cfg_stage_q == 2'h1) ? STAGE2_HI : STAGE3_HI;
    wire       cfg_adv    = load_pulse && !armed_q && (ctrl_q[15:8] == stage_hi);
    wire       idle       = (state_q == ST_IDLE);
    wire       rd_go      = rd_pulse && idle;
    wire       prog_go    = prog_pulse && armed_q && idle;
    wire       mem_rd     = (state_q == ST_BOOT) || rd_go;
    wire [10:0] mem_addr  = (state_q == ST_BOOT) ? SPECIAL_ADDR : adr_q[10:0];

    // host registers; a program pulse leaves data and address untouched
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wdat_q <= WDAT_RST;
            adr_q  <= ADR_RST;
            ctrl_q <= CTRL_RST;
        end else if (ev_wr) begin
            if (hit_wdat) begin
                wdat_q[{i_wdat[1:0], 3'h0} +: 8] <= req_data_q;
            end
            if (hit_adr) begin
                adr_q[{i_adr[0], 3'h0} +: 8] <= req_data_q;
            end
            if (hit_ctrl) begin
                ctrl_q[{i_ctrl[0], 3'h0} +: 8] <= req_data_q;
            end
        end
    end

    // configuration stages; only reset leaves programming mode
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cfg_stage_q <= 2'h0;
            armed_q     <= 1'b0;
        end else if (cfg_adv) begin
            cfg_stage_q <= cfg_stage_q + 2'h1;
            if (cfg_stage_q == LAST_STAGE) begin
                armed_q <= 1'b1;
            end
        end
    end

    assign prog_config_active_out = armed_q;

    // boot loads the special word, then host reads
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_BOOT:      state_d = ST_BOOT_WAIT;
            ST_BOOT_WAIT: state_d = ST_IDLE;
            ST_IDLE:      state_d = rd_go ? ST_READ_WAIT : ST_IDLE;
            ST_READ_WAIT: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_q <= ST_BOOT;
        end else begin
            state_q <= state_d;
        end
    end

    // result registers only change when their read lands
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdat_q    <= RDAT_RST;
            special_q <= SPECIAL_RST;
        end else begin
            if (state_q == ST_BOOT_WAIT) begin
                special_q <= mem_rdata;
            end
            if (state_q == ST_READ_WAIT) begin
                rdat_q <= mem_rdata;
            end
        end
    end

    otp_word_array u_array (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .rd_en_in  (mem_rd),
        .wr_en_in  (prog_go),
        .addr_in   (mem_addr),
        .wdata_in  (wdat_q),
        .rdata_out (mem_rdata)
    );

    // straps are caught once, after the synchroniser has filled
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            strap_s1_q    <= 2'h0;
            strap_s2_q    <= 2'h0;
            strap_s3_q    <= 2'h0;
            strap_q       <= 2'h0;
            strap_age_q   <= 2'h0;
            strap_taken_q <= 1'b0;
        end else begin
            strap_s1_q <= {mode_strap_pin_high_in, mode_strap_pin_low_in};
            strap_s2_q <= strap_s1_q;
            strap_s3_q <= strap_s2_q;
            if (!strap_taken_q) begin
                if (strap_age_q != STRAP_SETTLE) begin
                    strap_age_q <= strap_age_q + 2'h1;
                end else if (strap_s2_q == strap_s3_q) begin
                    strap_q       <= strap_s3_q;
                    strap_taken_q <= 1'b1;
                end
            end
        end
    end

    // serial mode select; the link itself always runs mode 0
    wire ovr_en  = (special_q[SPW_EN_HI:SPW_EN_LO] == SPW_EN_VAL);
    wire phase_d = ovr_en ? special_q[SPW_PH_POS] : strap_q[1];
    wire pol_d   = ovr_en ? special_q[SPW_POL_POS] : strap_q[0];

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            phase_q <= 1'b0;
            pol_q   <= 1'b0;
        end else begin
            phase_q <= phase_d;
            pol_q   <= pol_d;
        end
    end

    assign serial_clock_phase_out    = phase_q;
    assign serial_clock_polarity_out = pol_q;

    // checks on the system domain
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);

    a_boot_sequence: assert property ((state_q == ST_BOOT) |=> (state_q == ST_BOOT_WAIT) ##1 idle)
        else $error("boot load of special word did not finish in two cycles");
    a_boot_special: assert property ((state_q == ST_BOOT_WAIT) |=> special_q == $past(mem_rdata))
        else $error("special word not taken from otp after boot");
    a_special_read: assert property (ev_rd && req_addr_q == OFF_SPECIAL |=> rd_byte_q == special_q[7:0])
        else $error("special word byte not returned on link read");
    a_override_mode: assert property (ovr_en |=> phase_q == $past(special_q[1]) && pol_q == $past(special_q[0]))
        else $error("override phase or polarity not applied");
    a_strap_mode: assert property (!ovr_en |=> phase_q == $past(strap_q[1]) && pol_q == $past(strap_q[0]))
        else $error("strap mode not used without override");
    a_strap_ignored: assert property (ovr_en && $stable(special_q) |=> $stable({phase_q, pol_q}))
        else $error("serial mode moved while override active");
    a_retry_keeps: assert property (prog_pulse |=> $stable(wdat_q) && $stable(adr_q))
        else $error("program pulse disturbed data or address");
    a_prog_armed: assert property (prog_go |-> armed_q && cfg_stage_q == 2'h3)
        else $error("otp programmed outside programming configuration");
    a_boot_normal: assert property ((state_q == ST_BOOT) |-> !armed_q && cfg_stage_q == 2'h0)
        else $error("programming configuration survived reset");
    a_read_result: assert property (rd_go |=> ##1 rdat_q == $past(mem_rdata))
        else $error("read result not presented two cycles after pulse");
    a_rdat_hold: assert property ((state_q != ST_READ_WAIT) |=> $stable(rdat_q))
        else $error("read data changed without a read");

    c_read_done: cover property (rd_go ##2 idle);
    c_program: cover property (prog_go);
    c_override: cover property (ovr_en && strap_taken_q);
    c_link_write: cover property (ev_wr && hit_wdat);
endmodule

// ==== sim/link_host_model.sv ====
// host side model: serial register frames into the sequencer
`timescale 1ns/10ps
module link_host_model (
    output logic      link_clk_out,
    output logic      link_sel_n_out,
    output logic      link_mosi_out,
    input  wire logic link_miso_in,
    input  wire logic link_miso_oe_in
);
    // link clock stands low between frames
    initial begin
        link_clk_out   = 1'b0;
        link_sel_n_out = 1'b1;
        link_mosi_out  = 1'b0;
    end

    // one byte msb first: launch while clock low, capture miso at the rise
    task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            link_mosi_out = tx[i];
            #40 link_clk_out = 1'b1;
            rx[i] = link_miso_oe_in ? link_miso_in : 1'bx; // undriven miso never matches
            #40 link_clk_out = 1'b0;
        end
    endtask

    // header, dummy byte on reads, then n bytes little-endian
    task automatic frame(input logic wr, input logic [6:0] off, input int n,
                         input logic [31:0] wdat, output logic [31:0] rdat);
        logic [7:0] rx;
        rdat = 32'h0000_0000;
        #7 link_sel_n_out = 1'b0; // odd offset keeps the link out of phase with clk_in
        shift_byte({wr, off}, rx);
        if (!wr) begin
            shift_byte(8'h00, rx);
        end
        for (int b = 0; b < n; b++) begin
            shift_byte(wdat[8*b +: 8], rx);
            rdat[8*b +: 8] = rx;
        end
        #40 link_sel_n_out = 1'b1;
        link_mosi_out = ~link_mosi_out; // released line shows no stale level
        #80;
    endtask
endmodule

// ==== sim/otp_program_read_sequencer_test.sv ====
// self-checking bench for the otp access sequencer
`timescale 1ns/10ps
module otp_program_read_sequencer_test;
    import otp_seq_pkg::*;
    logic        clk_in, resetn_in, link_clk, link_sel_n, link_mosi, miso, miso_oe;
    logic        strap_hi, strap_lo, phase, polarity, prog_active;
    logic [31:0] rd;
    int          failures, check_count, cycles;

    otp_program_read_sequencer dut_u (.clk_in(clk_in), .resetn_in(resetn_in), .link_clk_in(link_clk),
        .link_sel_n_in(link_sel_n), .link_mosi_in(link_mosi), .link_miso_out(miso),
        .link_miso_oe_out(miso_oe), .mode_strap_pin_high_in(strap_hi), .mode_strap_pin_low_in(strap_lo),
        .serial_clock_phase_out(phase), .serial_clock_polarity_out(polarity),
        .prog_config_active_out(prog_active));
    link_host_model host_u (.link_clk_out(link_clk), .link_sel_n_out(link_sel_n), .link_mosi_out(link_mosi),
        .link_miso_in(miso), .link_miso_oe_in(miso_oe));

    always #5 clk_in = ~clk_in;

    // watchdog: the whole sequence needs far fewer cycles
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            failures = failures + 1;
            results();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic settle;
        repeat (12) @(posedge clk_in);
        @(negedge clk_in);
    endtask

    task automatic do_reset;
        @(posedge clk_in);
        resetn_in <= 1'b0;
        repeat (6) @(posedge clk_in);
        resetn_in <= 1'b1;
        settle();
    endtask

    // a write lands a few clk after its last bit
    task automatic reg_wr(input logic [6:0] off, input int n, input logic [31:0] d);
        logic [31:0] unused;
        host_u.frame(1'b1, off, n, d, unused);
        repeat (10) @(posedge clk_in);
    endtask

    task automatic reg_rd(input logic [6:0] off, input int n, output logic [31:0] d);
        host_u.frame(1'b0, off, n, 32'h0000_0000, d);
    endtask

    task automatic otp_read(input logic [10:0] a, output logic [31:0] d);
        reg_wr(OFF_ADR, 2, {21'h0, a});
        reg_wr(OFF_CTRL, 1, 32'h0000_0003);
        reg_wr(OFF_CTRL, 1, 32'h0000_0000);
        reg_rd(OFF_RDAT, 4, d);
    endtask

    // program pulse; the idle cycles stand in for the host wait
    task automatic pulse;
        reg_wr(OFF_CTRL, 1, 32'h0000_0040);
        reg_wr(OFF_CTRL, 1, 32'h0000_0000);
        repeat (20) @(posedge clk_in);
    endtask

    task automatic otp_prog(input logic [10:0] a, input logic [31:0] d);
        reg_wr(OFF_CTRL, 1, 32'h0000_0000);
        reg_wr(OFF_WDAT, 4, d);
        reg_wr(OFF_ADR, 2, {21'h0, a});
        pulse();
    endtask

    task automatic stage(input logic [7:0] hi, input logic [15:0] d, input logic [7:0] hi2);
        reg_wr(OFF_CTRL_HI, 1, {24'h0, hi});
        reg_wr(OFF_WDAT, 2, {16'h0, d});
        reg_wr(OFF_CTRL, 1, {24'h0, CTRL_CFG_LOAD});
        repeat (20) @(posedge clk_in);
        reg_wr(OFF_CTRL_HI, 1, {24'h0, hi2});
        if (hi2 != 8'h00) begin
            reg_wr(OFF_CTRL, 1, 32'h0000_0088);
            reg_wr(OFF_CTRL, 1, 32'h0000_0080);
            reg_wr(OFF_CTRL, 1, 32'h0000_0000);
        end
        @(negedge clk_in);
    endtask

    task automatic results;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        clk_in      = 1'b0;
        resetn_in   = 1'b0;
        strap_hi    = 1'b1;
        strap_lo    = 1'b0;
        failures    = 0;
        check_count = 0;
        cycles      = 0;
        do_reset();
        // blank special word leaves the straps in charge
        check(phase, 1'b1);
        check(polarity, 1'b0);
        // straps are taken once after reset, so a later change is not seen
        @(posedge clk_in);
        strap_hi <= 1'b0;
        strap_lo <= 1'b1;
        settle();
        check(phase, 1'b1);
        check(polarity, 1'b0);
        do_reset();
        check(phase, 1'b0);
        check(polarity, 1'b1);
        // reset values, read-only and unmapped offsets
        reg_rd(OFF_WDAT, 4, rd);
        check(rd, WDAT_RST);
        reg_rd(OFF_ADR, 4, rd);
        check(rd, {CTRL_RST, ADR_RST});
        reg_wr(OFF_RDAT, 4, 32'hFFFF_FFFF);
        reg_rd(OFF_RDAT, 4, rd);
        check(rd, RDAT_RST);
        reg_rd(OFF_SPECIAL, 4, rd);
        check(rd, SPECIAL_RST);
        reg_rd(7'h20, 1, rd);
        check(rd, 32'h0000_0000);
        // a pulse outside programming mode stores nothing
        otp_prog(11'h7FF, 32'hA5A5_0F0F);
        otp_read(11'h7FF, rd);
        check(rd, 32'h0000_0000);
        // three configuration stages
        stage(STAGE1_HI, 16'h9220, 8'h02);
        check(prog_active, 1'b0);
        stage(STAGE2_HI, 16'h000E, 8'h04);
        check(prog_active, 1'b0);
        stage(STAGE3_HI, 16'h1024, 8'h00);
        check(prog_active, 1'b1);
        // program, retry the pulse alone, registers must still hold
        otp_prog(11'h155, 32'h1234_5678);
        pulse();
        reg_rd(OFF_WDAT, 4, rd);
        check(rd, 32'h1234_5678);
        reg_rd(OFF_ADR, 2, rd);
        check(rd, 32'h0000_0155);
        otp_read(11'h155, rd);
        check(rd, 32'h1234_5678);
        // special word: override on, phase 1, polarity 0, reserved bits zero
        otp_prog(SPECIAL_ADDR, 32'h0000_000A);
        otp_read(SPECIAL_ADDR, rd);
        check(rd, 32'h0000_000A);
        repeat (50) @(posedge clk_in);
        reg_rd(OFF_RDAT, 4, rd);
        check(rd, 32'h0000_000A);
        // full reset ends programming mode and loads the special word
        @(posedge clk_in);
        strap_hi <= 1'b0;
        strap_lo <= 1'b1;
        do_reset();
        check(prog_active, 1'b0);
        reg_rd(OFF_SPECIAL, 4, rd);
        check(rd, 32'h0000_000A);
        check(phase, 1'b1);
        check(polarity, 1'b0);
        @(posedge clk_in);
        strap_hi <= 1'b1;
        strap_lo <= 1'b1;
        settle();
        check(phase, 1'b1);
        check(polarity, 1'b0);
        otp_read(11'h155, rd);
        check(rd, 32'h1234_5678);
        results();
    end
endmodule
